// File: pkg/period_match_timer_pkg.sv
// Package for the period match timer: register map, field layout, resets.
// Assumes an APB slave with 32-bit data and word-aligned registers.
package period_match_timer_pkg;

    localparam logic [3:0] count_offset    = 4'h0;
    localparam logic [3:0] period_offset   = 4'h4;
    localparam logic [3:0] control_offset  = 4'h8;
    localparam logic [3:0] status_offset   = 4'hc;

    localparam int         presel_lsb      = 0;
    localparam int         run_bit         = 2;
    localparam int         postsel_lsb     = 3;
    localparam int         flag_bit        = 0;

    localparam logic [7:0] count_reset     = 8'h00;
    localparam logic [7:0] period_reset    = 8'hff;
    localparam logic [6:0] control_reset   = 7'h00;
    localparam logic [1:0] cyc_per_instr   = 2'h3;

    typedef enum logic [1:0] {
        div_one     = 2'b00,
        div_four    = 2'b01,
        div_sixteen = 2'b10
    } prescale_e;

endpackage : period_match_timer_pkg

// File: rtl/period_match_timer.sv
// Period match timer: 8-bit timer, period compare, prescaler, postscaler.
// Assumes pclk is the oscillator clock; instruction ticks are pclk/4.
// Function
// - Count advances per prescaled instruction tick.
// - Prescaler divides by one, four or sixteen.
// - Count compared with period; equality gives match.
// - Match clears count, advances postscale counter.
// - Postscale select picks one to sixteen matches.
// - Run bit starts and stops the timer.
// - Reset clears count, sets period all ones.
// - Count or control write clears both scalers.
// - Control write does not load or clear count.
// - Count and period readable and writable anytime.
// - Control bit seven ignores writes, reads zero.
// - Postscaled match produces the interrupt event.
// - Match offered as serial port shift clock.
module period_match_timer
    import period_match_timer_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             match_event,
    output logic             shift_clock,
    output logic             timer_event
);

    // Every flop of the block sits in this one record.
    typedef struct packed {
        logic [7:0]  timer_count;
        logic [7:0]  period_value;
        logic [6:0]  timer_control;
        logic [1:0]  instr_div;
        logic [3:0]  pre_count;
        logic [3:0]  post_count;
        logic        ack;
        logic        flag;
        logic        match;
        logic [31:0] rdata;
        logic        err;
    } state_s;

    state_s st_ff;
    state_s nxt_st;

    logic        access;
    logic        first_access;
    logic        wr_en;
    logic        rd_en;
    logic        page_zero;

    logic        hit_count;
    logic        hit_period;
    logic        hit_control;
    logic        hit_status;
    logic        mapped;

    logic        wr_count;
    logic        wr_period;
    logic        wr_control;
    logic        wr_status;
    logic        scaler_clear;
    logic        flag_clear;

    logic [1:0]  presel;
    logic [3:0]  postsel;
    logic        running;
    logic        instr_tick;
    logic [3:0]  pre_limit;
    logic        pre_tick;
    logic        equal;
    logic        match_now;
    logic        post_done;
    logic        flag_set;

    logic [1:0]  div_step;
    logic [3:0]  pre_step;
    logic [7:0]  count_step;
    logic [3:0]  post_step;
    logic [31:0] read_word;

    // The access phase is stretched by one cycle so that read data can come
    // from a flop: the first access cycle loads it, the second shows it.
    assign access       = psel && penable;
    assign first_access = access && !st_ff.ack;
    assign wr_en        = access && st_ff.ack && pwrite && pstrb[0];
    assign rd_en        = first_access && !pwrite;

    assign page_zero = paddr[11:4] == 8'h00;

    always_comb begin
        hit_count   = 1'b0;
        hit_period  = 1'b0;
        hit_control = 1'b0;
        hit_status  = 1'b0;
        if (page_zero) begin
            case (paddr[3:0])
                count_offset: begin
                    hit_count = 1'b1;
                end
                period_offset: begin
                    hit_period = 1'b1;
                end
                control_offset: begin
                    hit_control = 1'b1;
                end
                status_offset: begin
                    hit_status = 1'b1;
                end
                default: begin
                    hit_count = 1'b0;
                end
            endcase
        end
    end

    assign mapped = hit_count || hit_period || hit_control || hit_status;

    assign wr_count     = wr_en && hit_count;
    assign wr_period    = wr_en && hit_period;
    assign wr_control   = wr_en && hit_control;
    assign wr_status    = wr_en && hit_status;
    assign scaler_clear = wr_count || wr_control;
    assign flag_clear   = wr_status && pwdata[flag_bit];

    assign presel  = st_ff.timer_control[presel_lsb +: 2];
    assign postsel = st_ff.timer_control[postsel_lsb +: 4];
    assign running = st_ff.timer_control[run_bit];

    // Instruction clock is the oscillator divided by four.
    assign instr_tick = running && st_ff.instr_div == cyc_per_instr;

    // Codes 10 and 11 both divide by sixteen.
    always_comb begin
        case (presel)
            div_one: begin
                pre_limit = 4'h0;
            end
            div_four: begin
                pre_limit = 4'h3;
            end
            default: begin
                pre_limit = 4'hf;
            end
        endcase
    end

    assign pre_tick = instr_tick && st_ff.pre_count == pre_limit;

    // Compare runs every cycle, but a match only counts on a timer tick,
    // so a stopped timer sitting on the period raises no events.
    assign equal     = st_ff.timer_count == st_ff.period_value;
    assign match_now = pre_tick && equal;
    assign post_done = st_ff.post_count == postsel;
    assign flag_set  = match_now && post_done;

    // Free-running steps of each counter, before any register write.
    always_comb begin
        div_step = st_ff.instr_div;
        if (running) begin
            div_step = st_ff.instr_div + 2'h1;
        end
    end

    always_comb begin
        pre_step = st_ff.pre_count;
        if (pre_tick) begin
            pre_step = 4'h0;
        end else if (instr_tick) begin
            pre_step = st_ff.pre_count + 4'h1;
        end
    end

    always_comb begin
        count_step = st_ff.timer_count;
        if (match_now) begin
            count_step = count_reset;
        end else if (pre_tick) begin
            count_step = st_ff.timer_count + 8'h01;
        end
    end

    // The postscaler restarts once it has seen the selected number.
    always_comb begin
        post_step = st_ff.post_count;
        if (flag_set) begin
            post_step = 4'h0;
        end else if (match_now) begin
            post_step = st_ff.post_count + 4'h1;
        end
    end

    // Unused upper bits read as zero; control bit seven is not stored.
    always_comb begin
        read_word = 32'h0000_0000;
        if (page_zero) begin
            case (paddr[3:0])
                count_offset: begin
                    read_word[7:0] = st_ff.timer_count;
                end
                period_offset: begin
                    read_word[7:0] = st_ff.period_value;
                end
                control_offset: begin
                    read_word[6:0] = st_ff.timer_control;
                end
                status_offset: begin
                    read_word[flag_bit] = st_ff.flag;
                end
                default: begin
                    read_word = 32'h0000_0000;
                end
            endcase
        end
    end

    always_comb begin
        nxt_st             = st_ff;
        nxt_st.instr_div   = div_step;
        nxt_st.pre_count   = pre_step;
        nxt_st.timer_count = count_step;
        nxt_st.post_count  = post_step;
        nxt_st.match       = match_now;
        nxt_st.ack         = first_access;
        nxt_st.err         = first_access && !mapped;
        nxt_st.rdata       = 32'h0000_0000;

        if (rd_en) begin
            nxt_st.rdata = read_word;
        end

        if (wr_count) begin
            nxt_st.timer_count = pwdata[7:0];
        end

        if (wr_period) begin
            nxt_st.period_value = pwdata[7:0];
        end

        // A control write leaves the count on its own tick path.
        if (wr_control) begin
            nxt_st.timer_control = pwdata[6:0];
        end

        // Scalers restart together with the divide-by-four phase.
        if (scaler_clear) begin
            nxt_st.instr_div  = 2'h0;
            nxt_st.pre_count  = 4'h0;
            nxt_st.post_count = 4'h0;
        end

        // An event in the same cycle as the clear keeps the flag set.
        if (flag_clear) begin
            nxt_st.flag = 1'b0;
        end
        if (flag_set) begin
            nxt_st.flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff.timer_count   <= count_reset;
            st_ff.period_value  <= period_reset;
            st_ff.timer_control <= control_reset;
            st_ff.instr_div     <= 2'h0;
            st_ff.pre_count     <= 4'h0;
            st_ff.post_count    <= 4'h0;
            st_ff.ack           <= 1'b0;
            st_ff.flag          <= 1'b0;
            st_ff.match         <= 1'b0;
            st_ff.rdata         <= 32'h0000_0000;
            st_ff.err           <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // One wait state: pready, and pslverr for an unmapped address, rise in the second access cycle.
    assign pready      = st_ff.ack;
    assign prdata      = st_ff.rdata;
    assign pslverr     = st_ff.err;
    assign match_event = st_ff.match;
    assign shift_clock = st_ff.match;
    assign timer_event = st_ff.flag;

endmodule : period_match_timer

// File: testbench/period_match_timer_chk.sv
// Checker for the period match timer: bus and output timing properties.
// Sees only the top module's ports; bound to it at the foot of this file.
module period_match_timer_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        match_event,
    input wire logic        shift_clock,
    input wire logic        timer_event
);
    logic       acc, wr, bad, clr, run_ff;
    logic [1:0] idle_ff;
    assign acc = psel & penable;
    assign wr  = acc & pwrite & pstrb[0] & pready;
    assign bad = (paddr[11:4] != 8'h0) | (paddr[1:0] != 2'h0);
    assign clr = wr & (paddr == 12'hc) & pwdata[0];
    // Three stopped cycles let a match launched before the stop land first.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_ff  <= 1'b0;
            idle_ff <= 2'h0;
        end else begin
            if (wr && paddr == 12'h8) run_ff <= pwdata[2];
            if (run_ff) idle_ff <= 2'h0;
            else if (idle_ff != 2'h3) idle_ff <= idle_ff + 2'h1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ready_one_wait_a: assert property (
        pready == (acc && $past(acc) && !$past(pready)))
        else $error("bad pready");
    unmapped_error_a: assert property (pslverr == (pready && bad))
        else $error("bad pslverr");
    read_idle_zero_a: assert property (
        !(acc && !pwrite && !pready) |=> prdata == 0)
        else $error("prdata not idle");
    ctrl_top_zero_a: assert property (acc && !pwrite && paddr == 12'h8
        |=> prdata[31:7] == 25'h0) else $error("control bit 7 set");
    shift_is_match_a: assert property (shift_clock == match_event)
        else $error("shift clock differs");
    match_pulse_a: assert property (match_event |=> !match_event)
        else $error("match too long");
    stop_no_match_a: assert property (idle_ff == 2'h3 |-> !match_event)
        else $error("match while stopped");
    flag_hold_a: assert property (timer_event && !clr |=> timer_event)
        else $error("flag lost");
    flag_cause_a: assert property ($rose(timer_event)
        |-> match_event || $past(match_event)) else $error("flag no match");
endmodule : period_match_timer_chk

bind period_match_timer period_match_timer_chk i_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .match_event(match_event), .shift_clock(shift_clock),
    .timer_event(timer_event));

// File: testbench/period_match_timer_tb.sv
// Testbench for the period match timer: APB register tests and timing.
// Assumes the checker is bound to the design from its own file.
module period_match_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, prdata;
    logic        slv, pready, pslverr, match_event, shift_clock, timer_event;
    int          miscompares = 0, tests_run = 0, n, m, i;
    always #20 pclk = ~pclk;
    period_match_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .match_event(match_event), .shift_clock(shift_clock),
        .timer_event(timer_event));
    task report_and_stop;
        $display("Compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Data and error are taken at the edge where pready is seen high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        slv = pslverr;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rchk
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rchk(12'h0, 32'h0);
        rchk(12'h4, 32'hff);
        apb(1'b1, 12'h0, 32'h5a);
        apb(1'b1, 12'h8, 32'h78);
        rchk(12'h0, 32'h5a);
        apb(1'b1, 12'h8, 32'hff);
        rchk(12'h8, 32'h7f);
        apb(1'b1, 12'h4, 32'h2);
        rchk(12'h4, 32'h2);
        rchk(12'h10, 32'h0);
        check({31'h0, slv}, 32'h1);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, 12'h8, 32'hc | i);
            do @(posedge pclk); while (match_event !== 1'b1);
            n = 0;
            do begin
                @(posedge pclk);
                n++;
            end while (match_event !== 1'b1);
            check(n, 12 * (i == 0 ? 1 : (i == 1 ? 4 : 16)));
        end
        for (i = 0; i < 16; i++) begin
            apb(1'b1, 12'h8, 32'h0);
            apb(1'b1, 12'h0, 32'h0);
            apb(1'b1, 12'hc, 32'h1);
            rchk(12'hc, 32'h0);
            apb(1'b1, 12'h8, 32'h4 | (i << 3));
            m = 0;
            while (timer_event !== 1'b1) begin
                @(posedge pclk);
                if (match_event === 1'b1) m++;
            end
            check(m, i + 1);
        end
        apb(1'b1, 12'h8, 32'h0);
        apb(1'b0, 12'h0, 32'h0);
        m = rd;
        repeat (40) @(posedge pclk);
        rchk(12'h0, m);
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        report_and_stop;
    end
endmodule : period_match_timer_tb
